// ===== rtl/bsl_regs.svh
// Constants for the boot strap latch: offsets, bit positions and timing
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH

// Register offsets on the plain port
`define BSL_OFF_STRAPS 4'h0
`define BSL_OFF_CTRL 4'h1
`define BSL_OFF_STATUS 4'h2
// Power management register holding the auto-reset enable
`define BSL_OFF_PM56 4'h6

// Positions inside the captured strap word
`define BSL_BIT_TEST 0
`define BSL_BIT_PLATFORM 1
`define BSL_BIT_PLL 2
`define BSL_BIT_NUMERR 3
`define BSL_BIT_A20 4
`define BSL_BIT_MASKABLE_IRQ_OUT 5
`define BSL_BIT_NMI 6
`define BSL_BIT_LEGACY 7
`define BSL_BIT_ROMSEL 8
// Auto-reset enable bit in the power management register
`define BSL_BIT_PM_AUTORST 6

// Timing
`define BSL_CLK_PERIOD_PS 5000
`define BSL_HOLD_CLKS 7
`define BSL_AUTORST_PERIOD_MS 5000
`define BSL_RST_PULSE_CLKS 16

`endif

// ===== rtl/bsl_pkg.sv
// Types shared by the boot strap latch modules
package bsl_pkg;
  typedef logic [8:0] bsl_straps_t;
  typedef enum logic [1:0] {
    BSL_SB_IDLE = 2'b00,
    BSL_SB_DRIVE = 2'b01,
    BSL_SB_HOLD = 2'b10
  } bsl_sb_state_e;
endpackage : bsl_pkg

// ===== rtl/bsl_link_if.sv
// Interface between the strap latch top and its sideband forwarding helper
`timescale 1ns/1ps
`default_nettype none
interface bsl_link_if;
  logic cpu_reset;
  logic [3:0] speed_level;
  logic [3:0] sideband;
  logic sideband_en;
  modport top (output cpu_reset, output speed_level, input sideband, input sideband_en);
  modport fwd (input cpu_reset, input speed_level, output sideband, output sideband_en);
endinterface : bsl_link_if
`default_nettype wire

// ===== rtl/bsl_sideband_fwd.sv
// Forwards speed strap levels to processor sideband pins around cpu reset
`timescale 1ns/1ps
`default_nettype none
`include "bsl_regs.svh"
module bsl_sideband_fwd (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Link to the top
  bsl_link_if.fwd link
);
  bsl_pkg::bsl_sb_state_e state_reg;
  bsl_pkg::bsl_sb_state_e state_next;
  logic [2:0] hold_cnt_reg; // Cycles spent after reset release
  logic [2:0] hold_cnt_next;
  logic [3:0] side_reg; // Levels driven out
  logic [3:0] side_next;
  wire hold_done = (hold_cnt_reg == 3'(`BSL_HOLD_CLKS - 1));

  // Next-state decode; the pin level follows the strap live during reset
  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    side_next = side_reg;
    case (state_reg)
      bsl_pkg::BSL_SB_IDLE: begin
        if (link.cpu_reset) begin
          state_next = bsl_pkg::BSL_SB_DRIVE;
          side_next = link.speed_level;
        end
      end
      bsl_pkg::BSL_SB_DRIVE: begin
        side_next = link.speed_level;
        hold_cnt_next = 3'h0;
        if (!link.cpu_reset) begin
          state_next = bsl_pkg::BSL_SB_HOLD;
        end
      end
      bsl_pkg::BSL_SB_HOLD: begin
        // Keeps forwarding 7 clocks past release
        side_next = link.speed_level;
        if (link.cpu_reset) begin
          state_next = bsl_pkg::BSL_SB_DRIVE;
        end else if (hold_done) begin
          state_next = bsl_pkg::BSL_SB_IDLE;
        end else begin
          hold_cnt_next = hold_cnt_reg + 3'h1;
        end
      end
      default: begin
        state_next = bsl_pkg::BSL_SB_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= bsl_pkg::BSL_SB_IDLE;
      hold_cnt_reg <= 3'h0;
      side_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      side_reg <= side_next;
    end
  end

  assign link.sideband = side_reg;
  assign link.sideband_en = (state_reg != bsl_pkg::BSL_SB_IDLE);
endmodule // bsl_sideband_fwd
`default_nettype wire

// ===== rtl/bsl_auto_reset.sv
// Periodic reset pulse generator for the system auto-reset function
`timescale 1ns/1ps
`default_nettype none
`include "bsl_regs.svh"
module bsl_auto_reset #(
  parameter int unsigned PERIOD_CLKS = 1000000000,
  parameter int unsigned PULSE_CLKS = `BSL_RST_PULSE_CLKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic enable_i,
  // Pulse request, high while reset is to be asserted
  output logic pulse_o
);
  // Elaboration check: the pulse has to fit inside one period
  if (PULSE_CLKS < 1 || PULSE_CLKS >= PERIOD_CLKS) begin : g_bad_pulse
    $error("bsl_auto_reset: pulse must be shorter than period");
  end
  logic [31:0] cnt_reg; // Position in the period
  logic [31:0] cnt_next;
  logic pulse_reg;
  logic pulse_seen_reg; // Set after first full period, so no pulse right at enable
  wire wrap = (cnt_reg == PERIOD_CLKS - 1);
  assign cnt_next = (!enable_i || wrap) ? 32'h0 : cnt_reg + 32'h1;

  // Counter runs only while enabled, restarting from zero when re-enabled
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 32'h0;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= enable_i && wrap;
    end
  end
  // Pulse sits at the start of each period window, after the wrap
  assign pulse_o = enable_i && (pulse_reg || (cnt_reg < PULSE_CLKS && cnt_reg != 32'h0 &&
                   pulse_seen_reg));
  // Remembers that one full period has gone by since enable
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_seen_reg <= 1'b0;
    end else begin
      pulse_seen_reg <= enable_i && (pulse_seen_reg || wrap);
    end
  end
endmodule // bsl_auto_reset
`default_nettype wire

// ===== rtl/bsl_strap_latch.sv
// Boot strap latch: captures straps at power-good and applies them
`timescale 1ns/1ps
`default_nettype none
`include "bsl_regs.svh"

// Operation
// R1: Capture strap pins on power-good rising edge
// R2: Pull-up captures one, pull-down captures zero
// R3: Rom-select high enables periodic pci reset
// R4: Writing zero to pm bit stops autoreset
// R5: Legacy strap routes rom cycles legacy/lpc
// R6: Nmi output follows strap through reset+7
// R7: Irq output follows strap through reset+7
// R8: A20 mask follows strap through reset+7
// R9: Ignore-error follows strap through reset+7
// R10: Board straps old platform pins correctly
// R11: Pll strap high enables internal pll
// R12: Platform strap high selects older platform
// R13: Test strap low enters nand test
// R14: Captured straps hold until next capture
module bsl_strap_latch #(
  parameter int unsigned AUTORST_PERIOD_CLKS =
    int'((64'(`BSL_AUTORST_PERIOD_MS) * 64'd1000000000) / 64'(`BSL_CLK_PERIOD_PS))
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Strap pins and qualifiers, asynchronous
  input wire logic rom_select_strap_i,
  input wire logic [7:0] system_addr_straps_i,
  input wire logic power_good_i,
  input wire logic cpu_reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Applied settings
  output logic pci_reset_out_b_o,
  output logic rom_to_legacy_o,
  output logic pll_enable_o,
  output logic platform_older_o,
  output logic nand_test_mode_o,
  // Processor sideband pins, outputs with an active-low enable
  output logic nmi_out_o,
  output logic maskable_irq_out_o,
  output logic addr20_mask_out_o,
  output logic ignore_numeric_error_out_o,
  output logic sideband_oe_b_o
);
  // Elaboration check: a period no longer than the pulse cannot be served
  if (AUTORST_PERIOD_CLKS <= `BSL_RST_PULSE_CLKS) begin : g_bad_period
    $error("bsl_strap_latch: auto-reset period too short");
  end

  // Two-stage synchronisers for every pin input
  logic [10:0] sync1_reg; // First stage, read only by second
  logic [10:0] sync2_reg;
  wire [10:0] pins = {cpu_reset_i, power_good_i, rom_select_strap_i, system_addr_straps_i};
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  wire [8:0] strap_live = sync2_reg[8:0]; // Rom select above address straps
  wire pg_sync = sync2_reg[9];
  wire cpu_reset_sync = sync2_reg[10];

  // Edge detect on the synchronised power-good
  logic pg_prev_reg;
  wire pg_rise = pg_sync && !pg_prev_reg;

  // Captured strap word
  bsl_pkg::bsl_straps_t straps_reg;
  logic captured_reg; // Set once a capture happened
  logic pm_autorst_reg; // Software auto-reset allow bit
  logic pm_autorst_next;
  logic [3:0] ctrl_reg; // Scratch control bits for software
  wire wr_pm = reg_wr_i && (reg_addr_i == `BSL_OFF_PM56);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `BSL_OFF_CTRL);
  assign pm_autorst_next = wr_pm ? reg_wdata_i[`BSL_BIT_PM_AUTORST] : pm_autorst_reg; // see R4

  // Capture happens only on the rising edge, so later pin activity is ignored
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pg_prev_reg <= 1'b0;
      straps_reg <= 9'h000;
      captured_reg <= 1'b0;
    end else begin
      pg_prev_reg <= pg_sync;
      if (pg_rise) begin
        straps_reg <= strap_live; // see R1 // see R2 // see R14
        captured_reg <= 1'b1;
      end
    end
  end

  // Auto-reset enable; a fresh capture re-arms the software allow bit
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pm_autorst_reg <= 1'b1;
      ctrl_reg <= 4'h0;
    end else begin
      pm_autorst_reg <= pg_rise ? 1'b1 : pm_autorst_next; // see R4
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata_i[3:0];
      end
    end
  end

  wire autorst_en = captured_reg && straps_reg[`BSL_BIT_ROMSEL] && pm_autorst_reg; // see R3
  logic autorst_pulse;
  bsl_auto_reset #(
    .PERIOD_CLKS(AUTORST_PERIOD_CLKS),
    .PULSE_CLKS(`BSL_RST_PULSE_CLKS)
  ) u_auto_reset (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .enable_i(autorst_en),
    .pulse_o(autorst_pulse)
  );

  // Sideband forwarding helper
  bsl_link_if link ();
  assign link.cpu_reset = cpu_reset_sync;
  assign link.speed_level = {strap_live[`BSL_BIT_NMI], strap_live[`BSL_BIT_MASKABLE_IRQ_OUT],
                             strap_live[`BSL_BIT_A20], strap_live[`BSL_BIT_NUMERR]};
  bsl_sideband_fwd u_sideband (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .link(link)
  );

  // Register read decode
  wire [15:0] rd_mux =
    (reg_addr_i == `BSL_OFF_STRAPS) ? {7'h00, straps_reg} :
    (reg_addr_i == `BSL_OFF_CTRL) ? {12'h000, ctrl_reg} :
    (reg_addr_i == `BSL_OFF_STATUS) ? {13'h0, link.sideband_en, autorst_en, captured_reg} :
    (reg_addr_i == `BSL_OFF_PM56) ? 16'(pm_autorst_reg) << `BSL_BIT_PM_AUTORST :
    16'h0000;

  // Output registers; all top outputs come from flip-flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
      pci_reset_out_b_o <= 1'b1;
      rom_to_legacy_o <= 1'b0;
      pll_enable_o <= 1'b0;
      platform_older_o <= 1'b0;
      nand_test_mode_o <= 1'b0;
      nmi_out_o <= 1'b0;
      maskable_irq_out_o <= 1'b0;
      addr20_mask_out_o <= 1'b0;
      ignore_numeric_error_out_o <= 1'b0;
      sideband_oe_b_o <= 1'b1;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
      pci_reset_out_b_o <= !autorst_pulse; // see R3
      rom_to_legacy_o <= straps_reg[`BSL_BIT_LEGACY]; // see R5
      pll_enable_o <= straps_reg[`BSL_BIT_PLL]; // see R11
      platform_older_o <= straps_reg[`BSL_BIT_PLATFORM]; // see R12
      nand_test_mode_o <= captured_reg && !straps_reg[`BSL_BIT_TEST]; // see R13
      nmi_out_o <= link.sideband[3]; // see R6
      maskable_irq_out_o <= link.sideband[2]; // see R7
      addr20_mask_out_o <= link.sideband[1]; // see R8
      ignore_numeric_error_out_o <= link.sideband[0]; // see R9
      sideband_oe_b_o <= !link.sideband_en; // see R6
    end
  end
endmodule // bsl_strap_latch
`default_nettype wire

// ===== sim/bsl_board_straps.sv
// Board resistor model standing on the strap pins
`timescale 1ns/1ps
`default_nettype none
module bsl_board_straps (
  // Resistor choice, one bit per pin, high is pull-up
  input wire logic [8:0] pull_i,
  // Shared pin traffic after boot
  input wire logic busy_i,
  input wire logic [8:0] bus_i,
  // Strap pins
  output logic rom_select_strap_o,
  output logic [7:0] system_addr_straps_o
);
  // Resistors win only while no one else drives the shared pins
  assign {rom_select_strap_o, system_addr_straps_o} = busy_i ? bus_i : pull_i;
endmodule // bsl_board_straps
`default_nettype wire

// ===== sim/bsl_strap_latch_monitor.sv
// Port checker for the boot strap latch
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_latch_monitor (
  // Clock, reset and pins
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] system_addr_straps_i,
  input wire logic power_good_i,
  input wire logic cpu_reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Outputs watched
  input wire logic pci_reset_out_b_o,
  input wire logic rom_to_legacy_o,
  input wire logic pll_enable_o,
  input wire logic platform_older_o,
  input wire logic nand_test_mode_o,
  input wire logic nmi_out_o,
  input wire logic maskable_irq_out_o,
  input wire logic addr20_mask_out_o,
  input wire logic ignore_numeric_error_out_o,
  input wire logic sideband_oe_b_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic pg_q; // Power-good seen last edge
  logic [3:0] since_pg; // Saturating age of last capture
  // Settings may only move shortly after a capture
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pg_q <= 1'b0;
      since_pg <= 4'h0;
    end else begin
      pg_q <= power_good_i;
      since_pg <= (power_good_i && !pg_q) ? 4'h0 : (since_pg == 4'hF ? 4'hF : since_pg + 4'h1);
    end
  end
  sequence s_pg_rise;
    $rose(power_good_i);
  endsequence
  sequence s_cpu_held;
    (cpu_reset_i && $stable(system_addr_straps_i))[*6];
  endsequence
  chk_route_pll: assert property (s_pg_rise |-> ##6 (rom_to_legacy_o == $past(system_addr_straps_i[7], 6)
    && pll_enable_o == $past(system_addr_straps_i[2], 6))) else $error("route or pll wrong");
  chk_platform_test: assert property (s_pg_rise |-> ##6 (platform_older_o == $past(system_addr_straps_i[1], 6)
    && nand_test_mode_o == !$past(system_addr_straps_i[0], 6))) else $error("platform or test wrong");
  chk_capture_hold: assert property (since_pg > 4'h8 |->
    $stable({rom_to_legacy_o, pll_enable_o, platform_older_o, nand_test_mode_o})) else $error("settings moved");
  chk_sideband_level: assert property (s_cpu_held |-> !sideband_oe_b_o && {nmi_out_o, maskable_irq_out_o,
    addr20_mask_out_o, ignore_numeric_error_out_o} == system_addr_straps_i[6:3]) else $error("sideband level wrong");
  chk_sideband_release: assert property (s_cpu_held ##1 !cpu_reset_i |=>
    (!sideband_oe_b_o)[*6] ##[1:8] sideband_oe_b_o) else $error("sideband hold wrong");
  chk_pulse_width: assert property ($fell(pci_reset_out_b_o) |->
    (!pci_reset_out_b_o)[*8] ##1 (!pci_reset_out_b_o)[*8] ##1 pci_reset_out_b_o) else $error("pulse width wrong");
  chk_pm_stop: assert property (reg_wr_i && reg_addr_i == 4'h6 && !reg_wdata_i[6] && pci_reset_out_b_o
    |=> ##1 pci_reset_out_b_o[*8]) else $error("pulse after disable");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("stray read data");
endmodule // bsl_strap_latch_monitor
bind bsl_strap_latch bsl_strap_latch_monitor u_mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .system_addr_straps_i(system_addr_straps_i), .power_good_i(power_good_i), .cpu_reset_i(cpu_reset_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pci_reset_out_b_o(pci_reset_out_b_o), .rom_to_legacy_o(rom_to_legacy_o),
  .pll_enable_o(pll_enable_o), .platform_older_o(platform_older_o), .nand_test_mode_o(nand_test_mode_o),
  .nmi_out_o(nmi_out_o), .maskable_irq_out_o(maskable_irq_out_o), .addr20_mask_out_o(addr20_mask_out_o),
  .ignore_numeric_error_out_o(ignore_numeric_error_out_o), .sideband_oe_b_o(sideband_oe_b_o));
`default_nettype wire

// ===== sim/bsl_strap_latch_bench.sv
// Self-checking bench for the boot strap latch
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_latch_bench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [8:0] pull = 9'h000; // Board resistor set
  logic busy = 1'b0; // Shared pin traffic on
  logic [8:0] bus = 9'h000;
  logic rom_sel, pg = 1'b0, cpu = 1'b0, wr = 1'b0, rd = 1'b0, seen;
  logic [7:0] sa;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic pci_rst_b, legacy, pll, plat, nand_t, nmi, irq, a20, ignore_numeric_error_out, oe_b;
  int miscompares = 0;
  int samples_checked = 0;
  always #2.5 mclk_i = ~mclk_i;
  bsl_board_straps u_board (.pull_i(pull), .busy_i(busy), .bus_i(bus),
    .rom_select_strap_o(rom_sel), .system_addr_straps_o(sa));
  bsl_strap_latch #(.AUTORST_PERIOD_CLKS(100)) u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .rom_select_strap_i(rom_sel), .system_addr_straps_i(sa), .power_good_i(pg), .cpu_reset_i(cpu),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pci_reset_out_b_o(pci_rst_b), .rom_to_legacy_o(legacy), .pll_enable_o(pll),
    .platform_older_o(plat), .nand_test_mode_o(nand_t), .nmi_out_o(nmi), .maskable_irq_out_o(irq),
    .addr20_mask_out_o(a20), .ignore_numeric_error_out_o(ignore_numeric_error_out), .sideband_oe_b_o(oe_b));
  // Verdict and end of run
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // One write cycle, strobe dropped after its edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
  endtask
  // Read data are looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    cyc(1);
  endtask
  // Power-good low then high with the board straps settled
  task automatic capture(input logic [8:0] p, input logic [3:0] exp);
    pull <= p;
    pg <= 1'b0;
    cyc(4);
    pg <= 1'b1;
    cyc(10);
    #1 chk({12'h000, legacy, pll, plat, nand_t}, {12'h000, exp});
  endtask
  // Sideband pins during cpu reset and after its release
  task automatic sb(input logic [3:0] exp);
    cpu <= 1'b1;
    cyc(8);
    #1 chk({11'h000, oe_b, nmi, irq, a20, ignore_numeric_error_out}, {12'h000, exp});
    cyc(1);
    cpu <= 1'b0;
    cyc(6);
    #1 chk({15'h0000, oe_b}, 16'h0000);
    cyc(12);
    #1 chk({15'h0000, oe_b}, 16'h0001);
  endtask
  // Sees whether a reset pulse occurs in n cycles
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge mclk_i);
      if (pci_rst_b === 1'b0) seen = 1'b1;
    end
  endtask
  initial begin
    cyc(3);
    rst_b_i <= 1'b1;
    cyc(2);
    capture(9'h19F, 4'hE);
    rd_chk(4'h0, 16'h019F);
    rd_chk(4'h2, 16'h0003);
    rd_chk(4'h6, 16'h0040);
    wr_reg(4'h1, 16'h000A);
    rd_chk(4'h1, 16'h000A);
    sb(4'b0011);
    busy <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus <= (i % 2) ? 9'h000 : 9'h1FF;
      cyc(1);
    end
    busy <= 1'b0;
    cyc(4);
    #1 chk({12'h000, legacy, pll, plat, nand_t}, 16'h000E);
    rd_chk(4'h0, 16'h019F);
    watch(250);
    chk({15'h0000, seen}, 16'h0001);
    cyc(30);
    wr_reg(4'h6, 16'h0000);
    rd_chk(4'h6, 16'h0000);
    watch(300);
    chk({15'h0000, seen}, 16'h0000);
    wr_reg(4'hF, 16'hFFFF);
    rd_chk(4'hF, 16'h0000);
    capture(9'h0F0, 4'h9);
    rd_chk(4'h0, 16'h00F0);
    rd_chk(4'h2, 16'h0001);
    sb(4'b1110);
    watch(250);
    chk({15'h0000, seen}, 16'h0000);
    complete_run();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule // bsl_strap_latch_bench
`default_nettype wire
